// [logic/encoder_cmd_regs.vh]
`ifndef ENCODER_CMD_REGS_VH
`define ENCODER_CMD_REGS_VH
// register offsets on the serial register port
`define OFS_EW_MASK 8'h0c
`define OFS_STAT_CFG 8'h0d
`define OFS_ACC_CLR_A 8'h3d
`define OFS_ACC_CLR_B 8'h3e
`define OFS_I2C_REM 8'h5b
`define OFS_I2C_RSTART 8'h5c
`define OFS_I2C_REND 8'h5d
`define OFS_I2C_ID 8'h5e
`define OFS_SWITCH 8'h60
`define OFS_EVENT 8'h73
`define OFS_CMD 8'h75
`define OFS_STAT0 8'h76
`define OFS_STAT1 8'h77
// field positions
`define CFG_ACC_BIT 7
`define SW_PROT_HI 7
`define SW_PROT_LO 6
`define SW_CAP_BIT 0
// reset values
`define RST_EW_MASK 8'h00
`define RST_STAT_CFG 8'h00
`define RST_BYTE 8'h00
// command codes
`define CMD_NONE 8'h00
`define CMD_WRITE_ALL 8'h01
`define CMD_ABS 8'h03
`define CMD_VERNIER 8'h04
`define CMD_TURNS_CHK 8'h06
`define CMD_SOFT 8'h07
`define CMD_I2C 8'h0a
`define CMD_EVENT 8'h0b
`define CMD_SWITCH 8'h0c
`define CMD_CHECKSUM_VERIFY 8'h0d
`define CMD_CLK_HI 8'h0f
`define CMD_CLK_LO 8'h10
`define CMD_NOFUNC 8'h11
`define CMD_LAST 8'h14
// protection levels that allow the generic transfer, and its retry limit
`define PROT_OPEN 2'h0
`define PROT_SHIP_I2C 2'h2
`define I2C_RETRIES 2'h3
// display time step
`define CLK_PERIOD_NS 50
`define ERROR_MIN_DISPLAY_CODE_STEP_US 12500
`define ERROR_MIN_DISPLAY_CODE_STEP_CYC ((`ERROR_MIN_DISPLAY_CODE_STEP_US * 1000) / `CLK_PERIOD_NS)
`endif

// [logic/encoder_command_status_unit.v]
// What this block does
// - accumulate select 0 shows live status, 1 holds each flag once set, bar startup, eeprom error and running.
// - accumulated mode: reading 0x3d or 0x3e clears both accumulated status bytes.
// - error/warning bit presence and polarity follow the port A protocol.
// - mask bits 7..2 gate error sources, bits 1..0 warning; 0 enables.
// - with error pin mode selected, enabled errors pull the open-collector pin low.
// - error pin stays asserted at least code times 12.5 ms.
// - command code stays while queued, cleared to 0x00 on acceptance.
// - codes 0x01..0x14 are operations; 0x00, 0x11, 0x15..0xff do nothing.
// - 0x01 writes all with both checksums; 0x02 writes offsets only.
// - 0x03 redefines absolute value and restarts converters.
// - 0x04 vernier check sets period consistency error on mismatch.
// - 0x05 resyncs turns and offsets without restarting converters.
// - 0x06 turns check sets turns consistency error on mismatch.
// - 0x07 soft reset reloads configuration then redefines absolute value.
// - 0x08/0x09 preset recompute offsets; 0x09 also stores them.
// - 0x0a allowed only at protection 0 or 2; up to 3 retries.
// - transfer moves end minus start plus one bytes; id has rw bit.
// - 0x0b increments the 8-bit event counter, wrapping after 0xff.
// - 0x0c needs protection 0; swaps targets in while writing configuration.
// - 0x0d verifies checksums setting crc error; 0x0e recomputes them.
// - 0x0f/0x10 set/clear turns clock after capturing data pin; no turns source.
// - accumulated flags persist until read, 0x03/0x07 redefine or reset; three flags stay live.
// - captured data bit is 1 if data pin was high before clock change.
`timescale 1ns/1ps
`include "encoder_cmd_regs.vh"

module encoder_command_status_unit #(
   parameter [23:0] ERROR_MIN_DISPLAY_CODE_STEP = `ERROR_MIN_DISPLAY_CODE_STEP_CYC,
   parameter PB_W = 3,
   parameter [PB_W-1:0] ERR_PIN_MODE = 1
) (
   input wire ref_clk_i,
   input wire rst_n_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [7:0] reg_rdata_o,
   input wire [2:0] port_a_protocol_i,
   input wire [PB_W-1:0] port_b_function_i,
   input wire [1:0] protection_level_i,
   input wire [1:0] turns_source_mode_i,
   input wire [4:0] status0_live_i,
   input wire crc_err_i,
   input wire eeprom_link_err_i,
   input wire turns_link_err_i,
   input wire freq_abz_i,
   input wire freq_cnv_i,
   output reg exec_start_o,
   output reg [7:0] exec_code_o,
   input wire exec_done_i,
   input wire exec_fail_i,
   output reg [7:0] i2c_byte_count_o,
   output reg switch_active_o,
   output reg [2:0] port_a_protocol_target_o,
   output reg [1:0] protection_level_target_o,
   input wire turns_data_pin_i,
   output reg turns_clock_pin_o,
   output reg err_bit_o,
   output reg err_bit_en_o,
   output reg warn_bit_o,
   output reg warn_bit_en_o,
   output reg error_out_n_o,
   output reg error_out_oe_o
);

   localparam ST_IDLE = 2'b01;
   localparam ST_RUN = 2'b10;

   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [7:0] mask_ff;
   reg [7:0] cfg_ff;
   reg [7:0] i2c_rem_ff;
   reg [7:0] i2c_rstart_ff;
   reg [7:0] i2c_rend_ff;
   reg [7:0] i2c_id_ff;
   reg [7:0] event_ff;
   reg [7:0] cmd_ff;
   reg [7:0] run_code_ff;
   reg [1:0] retry_ff;
   reg cap_ff;
   reg period_err_ff;
   reg turns_err_ff;
   reg [4:0] acc0_ff;
   reg [7:0] acc1_ff;
   reg [23:0] hold_ff;
   reg mtd_s1_ff;
   reg mtd_s2_ff;

   // ---------------------------------------------------------------
   // register decode
   // ---------------------------------------------------------------
   wire wr_cmd = reg_wr_i && (reg_addr_i == `OFS_CMD);
   wire wr_event = reg_wr_i && (reg_addr_i == `OFS_EVENT);
   wire rd_stat = reg_rd_i && ((reg_addr_i == `OFS_STAT0) ||
                               (reg_addr_i == `OFS_STAT1));
   wire rd_clr = reg_rd_i && ((reg_addr_i == `OFS_ACC_CLR_A) ||
                              (reg_addr_i == `OFS_ACC_CLR_B));
   wire acc_sel = cfg_ff[`CFG_ACC_BIT];
   wire [2:0] error_min_display_code = cfg_ff[2:0];

   // ---------------------------------------------------------------
   // command acceptance
   // ---------------------------------------------------------------
   wire accept = (state_ff == ST_IDLE) && (cmd_ff != `CMD_NONE);
   wire is_noop = (cmd_ff == `CMD_NOFUNC) || (cmd_ff > `CMD_LAST);
   wire i2c_ok = (protection_level_i == `PROT_OPEN) ||
                 (protection_level_i == `PROT_SHIP_I2C);
   wire turns_free = (turns_source_mode_i == 2'h0);
   wire is_local = (cmd_ff == `CMD_EVENT) || (cmd_ff == `CMD_CLK_HI) ||
                   (cmd_ff == `CMD_CLK_LO);
   // refused commands are dropped like no-function codes
   wire refused = ((cmd_ff == `CMD_I2C) && !i2c_ok) ||
                  ((cmd_ff == `CMD_SWITCH) &&
                   (protection_level_i != `PROT_OPEN)) ||
                  (((cmd_ff == `CMD_CLK_HI) || (cmd_ff == `CMD_CLK_LO)) &&
                   !turns_free);
   wire launch = accept && !is_noop && !is_local && !refused;
   wire do_local = accept && is_local && !refused;
   wire run_done = (state_ff == ST_RUN) && exec_done_i;
   wire i2c_retry = run_done && (run_code_ff == `CMD_I2C) && exec_fail_i &&
                    (retry_ff != `I2C_RETRIES);
   wire redefine = launch && ((cmd_ff == `CMD_ABS) || (cmd_ff == `CMD_SOFT));
   // also the live command-busy status flag
   wire running = (state_ff == ST_RUN);

   // local commands finish at acceptance and never enter the run state
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (launch) begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (run_done && !i2c_retry) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state_ff <= ST_IDLE;
         cmd_ff <= `CMD_NONE;
         run_code_ff <= `CMD_NONE;
         retry_ff <= 2'h0;
         exec_start_o <= 1'b0;
         exec_code_o <= `CMD_NONE;
         switch_active_o <= 1'b0;
         i2c_byte_count_o <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         // a fresh write lands after the clear of an accepted one
         if (wr_cmd) begin
            cmd_ff <= reg_wdata_i;
         end else if (accept) begin
            cmd_ff <= `CMD_NONE;
         end
         exec_start_o <= launch || i2c_retry;
         if (launch) begin
            run_code_ff <= cmd_ff;
            exec_code_o <= cmd_ff;
            retry_ff <= 2'h0;
            switch_active_o <= (cmd_ff == `CMD_SWITCH);
            // an end below the start wraps modulo 256
            i2c_byte_count_o <= i2c_rend_ff - i2c_rstart_ff + 8'h01;
         // a retry keeps the protection decision made at launch
         end else if (i2c_retry) begin
            retry_ff <= retry_ff + 2'h1;
         end else if (run_done) begin
            switch_active_o <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // local commands, event counter and turns pins
   // ---------------------------------------------------------------
   // data pin comes from outside, two stages before anyone looks
   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         mtd_s1_ff <= 1'b0;
         mtd_s2_ff <= 1'b0;
      end else begin
         mtd_s1_ff <= turns_data_pin_i;
         mtd_s2_ff <= mtd_s1_ff;
      end
   end

   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         event_ff <= `RST_BYTE;
         cap_ff <= 1'b0;
         turns_clock_pin_o <= 1'b0;
      end else begin
         // command increment wins over a host write in the same cycle
         if (do_local && (cmd_ff == `CMD_EVENT)) begin
            event_ff <= event_ff + 8'h01;
         end else if (wr_event) begin
            event_ff <= reg_wdata_i;
         end
         if (do_local && (cmd_ff != `CMD_EVENT)) begin
            // sampled before the pin moves; the synchroniser adds two cycles of lag
            cap_ff <= mtd_s2_ff;
            turns_clock_pin_o <= (cmd_ff == `CMD_CLK_HI);
         end
      end
   end

   // ---------------------------------------------------------------
   // check results and status
   // ---------------------------------------------------------------
   wire chk_done = run_done && !i2c_retry;
   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         period_err_ff <= 1'b0;
         turns_err_ff <= 1'b0;
      end else begin
         // flags follow the last verdict of their own check
         if (chk_done && (run_code_ff == `CMD_VERNIER)) begin
            period_err_ff <= exec_fail_i;
         end
         if (chk_done && (run_code_ff == `CMD_TURNS_CHK)) begin
            turns_err_ff <= exec_fail_i;
         end
      end
   end

   // crc verify mismatch is reported by the checksum engine itself
   wire crc_flag = crc_err_i;
   wire [4:0] live0 = status0_live_i;
   wire [7:0] live1 = {crc_flag, eeprom_link_err_i, turns_link_err_i,
                       turns_err_ff, period_err_ff, freq_abz_i, freq_cnv_i,
                       running};
   // the clearing read still returns the value held before the clear
   wire acc_clear = acc_sel && (rd_stat || rd_clr || redefine);

   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         acc0_ff <= 5'h00;
         acc1_ff <= 8'h00;
      end else if (!acc_sel) begin
         acc0_ff <= live0;
         acc1_ff <= live1;
      end else if (acc_clear) begin
         // set wins over the clear so no event is lost
         acc0_ff <= live0;
         acc1_ff <= live1;
      end else begin
         acc0_ff <= acc0_ff | live0;
         acc1_ff <= acc1_ff | live1;
      end
   end

   // startup, eeprom error and running always show live
   wire [7:0] stat0 = acc_sel ? {3'h0, live0[4], acc0_ff[3:0]} :
                      {3'h0, live0};
   wire [7:0] stat1 = acc_sel ? {acc1_ff[7], live1[6], acc1_ff[5:1], live1[0]} :
                      live1;

   // ---------------------------------------------------------------
   // error and warning bits
   // ---------------------------------------------------------------
   wire amp_any = |stat0[3:0];
   wire err_now = (!mask_ff[7] && (stat1[5] || stat1[4])) ||
                  (!mask_ff[6] && stat1[3]) ||
                  (!mask_ff[5] && amp_any) ||
                  (!mask_ff[4] && stat1[6]) ||
                  (!mask_ff[3] && stat1[7]) ||
                  (!mask_ff[2] && stat1[0]);
   wire warn_now = (!mask_ff[1] && (stat1[2] || stat1[1])) ||
                   (!mask_ff[0] && amp_any);
   wire both_low = (port_a_protocol_i == 3'h2) || (port_a_protocol_i == 3'h7);
   wire err_low = both_low || (port_a_protocol_i == 3'h5);
   wire err_high = (port_a_protocol_i == 3'h6);
   // code times step; the upper half stays zero for any step below 2^21
   wire [47:0] hold_prod = {21'h0, error_min_display_code} * ERROR_MIN_DISPLAY_CODE_STEP;
   wire [23:0] hold_load = hold_prod[23:0];
   wire pin_mode = (port_b_function_i == ERR_PIN_MODE);
   wire pin_act = pin_mode && (err_now || (hold_ff != 24'h0));

   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         hold_ff <= 24'h0;
         err_bit_o <= 1'b0;
         err_bit_en_o <= 1'b0;
         warn_bit_o <= 1'b0;
         warn_bit_en_o <= 1'b0;
         error_out_n_o <= 1'b0;
         error_out_oe_o <= 1'b0;
      end else begin
         // the hold reloads while the error lasts, so it counts from its end
         if (err_now) begin
            hold_ff <= hold_load;
         end else if (hold_ff != 24'h0) begin
            hold_ff <= hold_ff - 24'h1;
         end
         // a bit that the protocol does not carry is held low
         err_bit_en_o <= err_low || err_high;
         err_bit_o <= err_high ? err_now : (err_low & !err_now);
         warn_bit_en_o <= both_low;
         warn_bit_o <= both_low & !warn_now;
         error_out_n_o <= 1'b0;
         // only ever pulled low, never driven high: wired-or safe
         error_out_oe_o <= pin_act;
      end
   end

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         mask_ff <= `RST_EW_MASK;
         cfg_ff <= `RST_STAT_CFG;
         i2c_rem_ff <= `RST_BYTE;
         i2c_rstart_ff <= `RST_BYTE;
         i2c_rend_ff <= `RST_BYTE;
         i2c_id_ff <= `RST_BYTE;
         port_a_protocol_target_o <= 3'h0;
         protection_level_target_o <= 2'h0;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            `OFS_EW_MASK: mask_ff <= reg_wdata_i;
            `OFS_STAT_CFG: cfg_ff <= {reg_wdata_i[7], 4'h0, reg_wdata_i[2:0]};
            `OFS_I2C_REM: i2c_rem_ff <= reg_wdata_i;
            `OFS_I2C_RSTART: i2c_rstart_ff <= reg_wdata_i;
            `OFS_I2C_REND: i2c_rend_ff <= reg_wdata_i;
            `OFS_I2C_ID: i2c_id_ff <= reg_wdata_i;
            `OFS_SWITCH: begin
               port_a_protocol_target_o <= reg_wdata_i[2:0];
               protection_level_target_o <= reg_wdata_i[`SW_PROT_HI:`SW_PROT_LO];
            end
            // read-only and unmapped offsets ignore writes
            default: begin
            end
         endcase
      end
   end

   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `OFS_EW_MASK: reg_rdata_o <= mask_ff;
            `OFS_STAT_CFG: reg_rdata_o <= cfg_ff;
            `OFS_I2C_REM: reg_rdata_o <= i2c_rem_ff;
            `OFS_I2C_RSTART: reg_rdata_o <= i2c_rstart_ff;
            `OFS_I2C_REND: reg_rdata_o <= i2c_rend_ff;
            `OFS_I2C_ID: reg_rdata_o <= i2c_id_ff;
            `OFS_SWITCH: reg_rdata_o <= {protection_level_target_o, 3'h0,
                                         port_a_protocol_target_o[2:1], cap_ff};
            `OFS_EVENT: reg_rdata_o <= event_ff;
            `OFS_STAT0: reg_rdata_o <= stat0;
            `OFS_STAT1: reg_rdata_o <= stat1;
            // command and clearing offsets read back as zero
            default: reg_rdata_o <= 8'h00;
         endcase
      end
   end

endmodule

// [bench/encoder_command_status_unit_checker.sv]
`timescale 1ns/1ps
module encoder_command_status_unit_checker #(
   parameter [23:0] ERROR_MIN_DISPLAY_CODE_STEP = 24'h4,
   parameter PB_W = 3,
   parameter [PB_W-1:0] ERR_PIN_MODE = 1
) (
   input wire ref_clk_i,
   input wire rst_n_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire [2:0] port_a_protocol_i,
   input wire [PB_W-1:0] port_b_function_i,
   input wire [1:0] protection_level_i,
   input wire [1:0] turns_source_mode_i,
   input wire exec_start_o,
   input wire [7:0] exec_code_o,
   input wire switch_active_o,
   input wire turns_clock_pin_o,
   input wire err_bit_en_o,
   input wire warn_bit_en_o,
   input wire error_out_n_o,
   input wire error_out_oe_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // -----------------------------------------
   // display time shadow
   // -----------------------------------------
   // the code is snooped from bus writes since the checker has no view of the register
   reg [2:0] code_ff;
   reg [31:0] hi_ff;
   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         code_ff <= 3'h0;
         hi_ff <= 32'h0;
      end else begin
         if (reg_wr_i && reg_addr_i == 8'h0d) code_ff <= reg_wdata_i[2:0];
         hi_ff <= error_out_oe_o ? hi_ff + 32'h1 : 32'h0;
      end
   end
   // -----------------------------------------
   // properties
   // -----------------------------------------
   a_start_pulse: assert property (exec_start_o |=> !exec_start_o)
      else $error("engine start longer than one cycle");
   a_start_code: assert property (exec_start_o |-> exec_code_o inside
      {[8'h01:8'h0a], [8'h0c:8'h0e], [8'h12:8'h14]}) else $error("bad code launched");
   a_xfer_prot: assert property (exec_start_o && exec_code_o == 8'h0a
      |-> $past(protection_level_i) inside {2'h0, 2'h2}) else $error("transfer at wrong level");
   a_switch_prot: assert property ($rose(switch_active_o)
      |-> $past(protection_level_i) == 2'h0) else $error("switch at wrong level");
   a_pin_mode: assert property (error_out_oe_o
      |-> $past(port_b_function_i) == ERR_PIN_MODE) else $error("pin driven off mode");
   a_pin_low: assert property (!error_out_n_o) else $error("pin driven high");
   a_err_present: assert property ($past(rst_n_i) |-> err_bit_en_o ==
      ($past(port_a_protocol_i) inside {3'h2, 3'h5, 3'h6, 3'h7})) else $error("err bit");
   a_warn_present: assert property ($past(rst_n_i) |-> warn_bit_en_o ==
      ($past(port_a_protocol_i) inside {3'h2, 3'h7})) else $error("warn bit");
   a_clk_source: assert property ($changed(turns_clock_pin_o)
      |-> $past(turns_source_mode_i) == 2'h0) else $error("clock pin moved with source");
   a_hold_time: assert property ($fell(error_out_oe_o)
      |-> hi_ff >= code_ff * ERROR_MIN_DISPLAY_CODE_STEP) else $error("error pin released early");
endmodule

bind encoder_command_status_unit encoder_command_status_unit_checker #(
   .ERROR_MIN_DISPLAY_CODE_STEP(ERROR_MIN_DISPLAY_CODE_STEP), .PB_W(PB_W), .ERR_PIN_MODE(ERR_PIN_MODE)) u_checker (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .port_a_protocol_i(port_a_protocol_i),
   .port_b_function_i(port_b_function_i), .protection_level_i(protection_level_i),
   .turns_source_mode_i(turns_source_mode_i), .exec_start_o(exec_start_o),
   .exec_code_o(exec_code_o), .switch_active_o(switch_active_o),
   .turns_clock_pin_o(turns_clock_pin_o), .err_bit_en_o(err_bit_en_o),
   .warn_bit_en_o(warn_bit_en_o), .error_out_n_o(error_out_n_o),
   .error_out_oe_o(error_out_oe_o));

// [bench/cmd_engine_model.sv]
`timescale 1ns/1ps
module cmd_engine_model (
   input wire ref_clk_i,
   input wire exec_start_i,
   input wire slow_i,
   output reg done_o,
   output reg busy_o,
   output reg [7:0] starts_o
);
   reg [3:0] wait_ff;
   initial begin
      done_o = 1'b0;
      busy_o = 1'b0;
      starts_o = 8'h00;
      wait_ff = 4'h0;
   end
   // slow answers keep the unit busy long enough to see a stalled engine
   always @(posedge ref_clk_i) begin
      done_o <= 1'b0;
      if (exec_start_i) begin
         busy_o <= 1'b1;
         starts_o <= starts_o + 8'h01;
         wait_ff <= slow_i ? 4'hc : 4'h1;
      end else if (busy_o) begin
         if (wait_ff == 4'h0) begin
            done_o <= 1'b1;
            busy_o <= 1'b0;
         end else begin
            wait_ff <= wait_ff - 4'h1;
         end
      end
   end
endmodule

// [bench/encoder_command_status_unit_tb.sv]
`timescale 1ns/1ps
module encoder_command_status_unit_tb;
   reg clk, rst_n, wr_s, rd_s, crc, tdata, efail, slow;
   reg [7:0] addr, wdata;
   reg [2:0] proto, pbf;
   reg [1:0] prot, tmode;
   reg [4:0] st0;
   wire [7:0] rdata, code, count, starts;
   wire start, done, sw, tclk, eb, ebe, eoe, busy, wb;
   wire [2:0] tpa;
   wire [1:0] tpl;
   integer num_errors, checked, i, n;
   encoder_command_status_unit #(.ERROR_MIN_DISPLAY_CODE_STEP(24'h4)) u_encoder_command_status_unit (
      .ref_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .port_a_protocol_i(proto),
      .port_b_function_i(pbf), .protection_level_i(prot), .turns_source_mode_i(tmode),
      .status0_live_i(st0), .crc_err_i(crc), .eeprom_link_err_i(1'b0),
      .turns_link_err_i(1'b0), .freq_abz_i(1'b0), .freq_cnv_i(1'b0),
      .exec_start_o(start), .exec_code_o(code), .exec_done_i(done), .exec_fail_i(efail),
      .i2c_byte_count_o(count), .switch_active_o(sw), .port_a_protocol_target_o(tpa),
      .protection_level_target_o(tpl), .turns_data_pin_i(tdata), .turns_clock_pin_o(tclk),
      .err_bit_o(eb), .err_bit_en_o(ebe), .warn_bit_o(wb), .warn_bit_en_o(),
      .error_out_n_o(), .error_out_oe_o(eoe));
   cmd_engine_model u_cmd_engine_model (.ref_clk_i(clk), .exec_start_i(start),
      .slow_i(slow), .done_o(done), .busy_o(busy), .starts_o(starts));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // -----------------------------------------
   // tasks
   // -----------------------------------------
   task chk(input string nm, input [7:0] seen, input [7:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("unexpected %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk);
         addr <= a; wdata <= d; wr_s <= 1'b1;
         @(posedge clk);
         wr_s <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [7:0] e);
      begin
         @(posedge clk);
         addr <= a; rd_s <= 1'b1;
         @(posedge clk);
         rd_s <= 1'b0;
         @(posedge clk);
         chk("rdata", rdata, e);
      end
   endtask
   // waits until neither the unit nor the engine has shown activity for four cycles
   task cmd(input [7:0] c);
      integer k, q;
      begin
         wr(8'h75, c);
         q = 0;
         for (k = 0; k < 300 && q < 4; k = k + 1) begin
            @(posedge clk);
            q = (busy || start) ? 0 : q + 1;
         end
      end
   endtask
   task close_out;
      begin
         if (num_errors == 0 && checked > 0) begin
            $display("verification passed");
         end else begin
            $display("verification failed");
         end
         $finish;
      end
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      num_errors = num_errors + 1;
      close_out;
   end
   // -----------------------------------------
   // tests
   // -----------------------------------------
   initial begin
      num_errors = 0; checked = 0; rst_n = 1'b0; wr_s = 1'b0; rd_s = 1'b0;
      crc = 1'b0; tdata = 1'b0; efail = 1'b0; slow = 1'b0; addr = 8'h00; wdata = 8'h00;
      proto = 3'h6; pbf = 3'h1; prot = 2'h0; tmode = 2'h0; st0 = 5'h00;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h0c, 8'h00);
      rd(8'h0d, 8'h00);
      for (i = 0; i < 4; i = i + 1) begin
         wr(8'h5b + i, 8'h5a ^ i);
         rd(8'h5b + i, 8'h5a ^ i);
      end
      rd(8'h40, 8'h00);
      wr(8'h73, 8'hff);
      cmd(8'h0b);
      rd(8'h73, 8'h00);
      cmd(8'h0b);
      rd(8'h73, 8'h01);
      n = starts;
      cmd(8'h11);
      cmd(8'h15);
      cmd(8'hff);
      chk("starts", starts, n);
      rd(8'h73, 8'h01);
      rd(8'h75, 8'h00);
      n = starts;
      cmd(8'h01);
      cmd(8'h02);
      cmd(8'h05);
      cmd(8'h08);
      cmd(8'h09);
      cmd(8'h0e);
      cmd(8'h12);
      chk("code", code, 8'h12);
      chk("engine", starts - n, 8'h07);
      // soft reset is never issued: the host would then owe 50 ms of silence
      efail <= 1'b1; slow <= 1'b1;
      cmd(8'h04);
      chk("code", code, 8'h04);
      rd(8'h77, 8'h08);
      cmd(8'h06);
      rd(8'h77, 8'h18);
      efail <= 1'b0; slow <= 1'b0;
      cmd(8'h04);
      cmd(8'h06);
      rd(8'h77, 8'h00);
      wr(8'h5c, 8'h10);
      wr(8'h5d, 8'h13);
      efail <= 1'b1; n = starts;
      cmd(8'h0a);
      chk("count", count, 8'h04);
      chk("tries", starts - n, 8'h04);
      efail <= 1'b0; prot <= 2'h1; n = starts;
      cmd(8'h0a);
      cmd(8'h0c);
      chk("refused", starts, n);
      prot <= 2'h2;
      cmd(8'h0a);
      prot <= 2'h0;
      cmd(8'h0c);
      chk("allowed", starts - n, 8'h02);
      tdata <= 1'b1;
      cmd(8'h0f);
      chk("clock", tclk, 8'h01);
      rd(8'h60, 8'h01);
      tdata <= 1'b0;
      cmd(8'h10);
      chk("clock", tclk, 8'h00);
      rd(8'h60, 8'h00);
      tmode <= 2'h1;
      cmd(8'h0f);
      chk("clock", tclk, 8'h00);
      tmode <= 2'h0;
      wr(8'h0d, 8'h80);
      @(posedge clk) st0 <= 5'h01;
      @(posedge clk) st0 <= 5'h00;
      rd(8'h3d, 8'h00);
      rd(8'h76, 8'h00);
      @(posedge clk) st0 <= 5'h01;
      @(posedge clk) st0 <= 5'h00;
      rd(8'h76, 8'h01);
      rd(8'h76, 8'h00);
      @(posedge clk) st0 <= 5'h01;
      @(posedge clk) st0 <= 5'h00;
      cmd(8'h03);
      rd(8'h76, 8'h00);
      wr(8'h0d, 8'h02);
      @(posedge clk) st0 <= 5'h01;
      @(posedge clk) st0 <= 5'h00;
      rd(8'h76, 8'h00);
      for (i = 0; i < 8; i = i + 1) @(posedge clk) proto <= i;
      wr(8'h0c, 8'hf7);
      @(posedge clk) proto <= 3'h6;
      crc <= 1'b1;
      repeat (3) @(posedge clk);
      chk("err_bit", eb, 8'h01);
      chk("oe", eoe, 8'h01);
      proto <= 3'h5;
      repeat (3) @(posedge clk);
      chk("err_bit", eb, 8'h00);
      crc <= 1'b0;
      repeat (9) @(posedge clk);
      chk("oe", eoe, 8'h01);
      repeat (3) @(posedge clk);
      chk("oe", eoe, 8'h00);
      wr(8'h0c, 8'hff);
      crc <= 1'b1;
      repeat (3) @(posedge clk);
      chk("oe", eoe, 8'h00);
      rd(8'h77, 8'h80);
      pbf <= 3'h2;
      proto <= 3'h7;
      wr(8'h0c, 8'hf6);
      repeat (3) @(posedge clk);
      chk("oe", eoe, 8'h00);
      chk("warn_bit", wb, 8'h01);
      st0 <= 5'h01;
      repeat (3) @(posedge clk);
      chk("warn_bit", wb, 8'h00);
      crc <= 1'b0;
      st0 <= 5'h00;
      wr(8'h60, 8'h87);
      rd(8'h60, 8'h86);
      chk("target", {5'h00, tpa}, 8'h07);
      chk("target", {6'h00, tpl}, 8'h02);
      close_out;
   end
endmodule
